/* pbc_mdio.sv */
// Serial management frame engine: preamble, header, turnaround and data
`timescale 1ns/1ps
module pbc_mdio
    import pbc_pkg::*;
(
    input  logic        clk,       // System clock
    input  logic        rst,       // Synchronous reset, active high
    input  logic        mdc_rise,  // Management clock rising edge seen
    input  logic        mdc_fall,  // Management clock falling edge seen
    input  logic        mdio_in,   // Synchronised management data
    input  logic [15:0] rd_data,   // Register read data
    output logic        rd_req,    // One-cycle read request
    output logic        wr_req,    // One-cycle write request
    output logic [4:0]  addr,      // Register address of request
    output logic [15:0] wr_data,   // Write data
    output logic        mdio_out,  // Data driven on the pin
    output logic        mdio_oe    // High while driving the pin
);
    typedef struct packed {
        pbc_mdio_st_t st;
        logic [5:0]   cnt;
        logic [15:0]  sh;
        logic [1:0]   op;
        logic [4:0]   addr;
        logic         rd_req;
        logic         wr_req;
        logic         out;
        logic         oe;
    } pbc_mdio_t;

    pbc_mdio_t r_reg;
    pbc_mdio_t r_next;
    logic [13:0] hdr;

    always_comb begin
        r_next = r_reg;
        r_next.rd_req = 1'b0;
        r_next.wr_req = 1'b0;
        hdr = {r_reg.sh[12:0], mdio_in};
        case (r_reg.st)
            PBC_MS_PRE: begin
                // Preamble is mandatory: a frame starts only after 32 ones
                if (mdc_rise) begin // R12 R17
                    if (mdio_in) begin
                        if (r_reg.cnt < 6'(PBC_PRE_BITS)) begin
                            r_next.cnt = r_reg.cnt + 6'd1;
                        end
                    end else if (r_reg.cnt == 6'(PBC_PRE_BITS)) begin
                        r_next.st = PBC_MS_HDR;
                        r_next.cnt = 6'd1;
                        r_next.sh = 16'h0000;
                    end else begin
                        r_next.cnt = 6'd0;
                    end
                end
            end
            PBC_MS_HDR: begin
                if (mdc_rise) begin
                    r_next.sh = {r_reg.sh[14:0], mdio_in};
                    r_next.cnt = r_reg.cnt + 6'd1;
                    if (r_reg.cnt == 6'(PBC_HDR_BITS - 1)) begin
                        r_next.cnt = 6'd0;
                        r_next.op = hdr[11:10];
                        r_next.addr = hdr[4:0];
                        if (hdr[13:12] == PBC_ST && hdr[9:5] == PBC_PHY_ADDR &&
                            (hdr[11:10] == PBC_OP_RD || hdr[11:10] == PBC_OP_WR)) begin
                            r_next.st = PBC_MS_TA;
                            r_next.rd_req = (hdr[11:10] == PBC_OP_RD);
                        end else begin
                            r_next.st = PBC_MS_PRE;
                        end
                    end
                end
            end
            PBC_MS_TA: begin
                // Read: release for one bit, then drive zero
                if (r_reg.op == PBC_OP_RD ? mdc_fall : mdc_rise) begin
                    if (r_reg.cnt == 6'd0) begin
                        r_next.cnt = 6'd1;
                    end else begin
                        r_next.st = PBC_MS_DATA;
                        r_next.cnt = 6'd0;
                        if (r_reg.op == PBC_OP_RD) begin
                            r_next.oe = 1'b1;
                            r_next.out = 1'b0;
                            r_next.sh = rd_data;
                        end
                    end
                end
            end
            PBC_MS_DATA: begin
                if (r_reg.op == PBC_OP_RD && mdc_fall) begin
                    if (r_reg.cnt == 6'(PBC_DATA_BITS)) begin
                        r_next.oe = 1'b0;
                        r_next.st = PBC_MS_PRE;
                        r_next.cnt = 6'd0;
                    end else begin
                        r_next.out = r_reg.sh[15];
                        r_next.sh = {r_reg.sh[14:0], 1'b0};
                        r_next.cnt = r_reg.cnt + 6'd1;
                    end
                end else if (r_reg.op == PBC_OP_WR && mdc_rise) begin
                    r_next.sh = {r_reg.sh[14:0], mdio_in};
                    r_next.cnt = r_reg.cnt + 6'd1;
                    if (r_reg.cnt == 6'(PBC_DATA_BITS - 1)) begin
                        r_next.wr_req = 1'b1;
                        r_next.st = PBC_MS_PRE;
                        r_next.cnt = 6'd0;
                    end
                end
            end
            default: begin
                r_next.st = PBC_MS_PRE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rd_req = r_reg.rd_req;
    assign wr_req = r_reg.wr_req;
    assign addr = r_reg.addr;
    assign wr_data = r_reg.sh;
    assign mdio_out = r_reg.out;
    assign mdio_oe = r_reg.oe;
endmodule

/* pbc_phy_regs.sv */
// PHY basic control and status registers behind the management link
// How it works
// R1: Writing control bit 15 resets all PHY registers; reads one until done.
// R2: Control bit 14 loops back; at 100 Mbps a 720 ms dead time follows.
// R3: Bit 13 selects 100 Mbps, resets one; reads negotiated speed under negotiation.
// R4: Bit 12 enables negotiation, resets one; clear lets bits 13 and 8 rule.
// R5: Bit 11 powers down everything but the oscillator; resets zero.
// R6: Bit 10 isolates the PHY from its MII data interface.
// R7: Bit 9 restarts negotiation, self-clears once started; inert when negotiation off.
// R8: Bit 8 selects full duplex, resets one; writable only without negotiation.
// R9: Bit 7 makes COL follow TX_EN for collision testing.
// R10: Reserved control and status bits read zero; the host writes them zero.
// R11: Ability bits are constants: T4 zero, all others one.
// R12: Status bit 6 reads zero; frames without preamble are refused.
// R13: Remote fault latches high until a status read or a reset.
// R14: Link status latches low on failure until a status read.
// R15: Jabber latches high, only at 10 Mbps, until a status read or reset.
// R16: Addresses 0-6 and 16-18 are defined; others read zero, writes ignored. Only 0 and 1 are decoded; the rest read zero.
// R17: The host bit-bangs clock and data; the device samples on clock edges.
// R18: A partner remote-fault indication drives the latched remote fault.
// R19: A status read returns the latch, then re-arms it to the live condition.
`timescale 1ns/1ps
module pbc_phy_regs
    import pbc_pkg::*;
#(
    parameter int unsigned LOOP_DEAD_CYCLES = pbc_pkg::PBC_LOOP_DEAD_CYC
) (
    input  logic SYS_CLK,         // System clock, 40 MHz
    input  logic SYS_RST,         // Chip reset, synchronous, active high
    input  logic MDC,             // Management clock pin
    input  logic MDIO_IN,         // Management data pin, input side
    output logic MDIO_OUT,        // Management data pin, output side
    output logic MDIO_OE,         // Management data pin enable
    input  logic TX_EN,           // Transmit enable from the MAC
    input  logic COL_LINE,        // Collision seen on the line
    output logic COL,             // Collision to the MAC
    input  logic LINK_OK,         // Live link condition
    input  logic JABBER,          // Live jabber condition
    input  logic PARTNER_FAULT,   // Partner remote-fault flag received
    input  logic AN_COMPLETE,     // Negotiation complete
    input  logic AN_SPEED_100,    // Negotiated speed is 100 Mbps
    input  logic AN_FULL_DUPLEX,  // Negotiated full duplex
    input  logic AN_STARTED,      // Negotiation engine has started
    output logic AN_RESTART,      // Negotiation restart request
    output logic AN_ENABLE,       // Negotiation enabled
    output logic SOFT_RESET,      // Software reset in progress
    output logic LOOPBACK,        // Internal loopback
    output logic SPEED_100,       // Effective speed is 100 Mbps
    output logic FULL_DUPLEX,     // Effective duplex is full
    output logic POWER_DOWN,      // Power down request
    output logic ISOLATE,         // MII isolate request
    output logic LOOP_DEAD        // Receive data not yet valid after loopback
);
    typedef struct packed {
        logic        loop;
        logic        spd;
        logic        an_en;
        logic        pdn;
        logic        iso;
        logic        dpx;
        logic        colt;
        logic        restart;
        logic        srst;
        logic [7:0]  srst_cnt;
        logic        fault;
        logic        link;
        logic        jab;
        logic [15:0] rd_data;
        logic        col;
        logic        spd_o;
        logic        dpx_o;
        logic        dead;
        logic [31:0] dead_cnt;
        logic        mdc_d;
    } pbc_top_t;

    localparam pbc_top_t RST_S = '{spd: PBC_SPD_RST, an_en: PBC_ANEN_RST,
                                   dpx: PBC_DPX_RST, spd_o: PBC_SPD_RST,
                                   dpx_o: PBC_DPX_RST, default: '0};

    pbc_top_t    r_reg;
    pbc_top_t    r_next;
    logic [1:0]  pin_s;
    logic        rd_req;
    logic        wr_req;
    logic [4:0]  addr;
    logic [15:0] wr_data;
    logic        spd_now;
    logic        dpx_now;
    logic        rd_stat;
    logic        wr_ctrl;
    logic        jab_ev;
    logic [15:0] ctrl_rd;
    logic [15:0] stat_rd;

    // ****************************************************************
    // Pin sampling and frame engine
    // ****************************************************************
    pbc_sync2 #(
        .WIDTH (2)
    ) u_sync (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .d   ({MDC, MDIO_IN}),
        .q   (pin_s)
    );

    pbc_mdio u_mdio (
        .clk      (SYS_CLK),
        .rst      (SYS_RST),
        .mdc_rise (pin_s[1] & ~r_reg.mdc_d),
        .mdc_fall (~pin_s[1] & r_reg.mdc_d),
        .mdio_in  (pin_s[0]),
        .rd_data  (r_reg.rd_data),
        .rd_req   (rd_req),
        .wr_req   (wr_req),
        .addr     (addr),
        .wr_data  (wr_data),
        .mdio_out (MDIO_OUT),
        .mdio_oe  (MDIO_OE)
    );

    // ****************************************************************
    // Register behaviour
    // ****************************************************************
    always_comb begin
        r_next = r_reg;
        r_next.mdc_d = pin_s[1];
        spd_now = r_reg.an_en ? AN_SPEED_100 : r_reg.spd; // R3
        dpx_now = r_reg.an_en ? AN_FULL_DUPLEX : r_reg.dpx; // R8
        ctrl_rd = {r_reg.srst, r_reg.loop, spd_now, r_reg.an_en, r_reg.pdn, r_reg.iso,
                   r_reg.restart, dpx_now, r_reg.colt, PBC_CTRL_RSV}; // R1 R10
        stat_rd = {PBC_STAT_ABIL, PBC_STAT_RSV, PBC_STAT_NOPRE, AN_COMPLETE, r_reg.fault,
                   PBC_STAT_ANAB, r_reg.link, r_reg.jab, PBC_STAT_EXT}; // R10 R11 R12
        rd_stat = rd_req && addr == PBC_REG_STAT;
        wr_ctrl = wr_req && addr == PBC_REG_CTRL && !r_reg.srst;
        jab_ev = JABBER & ~spd_now; // R15

        // Latches: a read hands out the held value and re-arms to live
        r_next.fault = rd_stat ? PARTNER_FAULT : (r_reg.fault | PARTNER_FAULT); // R13 R18 R19
        r_next.link = rd_stat ? LINK_OK : (r_reg.link & LINK_OK); // R14 R19
        r_next.jab = rd_stat ? jab_ev : (r_reg.jab | jab_ev); // R15 R19

        // Restart is dropped by the engine starting, by negotiation turning off or by a soft reset, never by a host write of zero
        r_next.restart = r_reg.restart & ~AN_STARTED & r_reg.an_en; // R7

        if (wr_ctrl) begin
            r_next.loop = wr_data[PBC_C_LOOP]; // R2
            r_next.an_en = wr_data[PBC_C_ANEN]; // R4
            r_next.pdn = wr_data[PBC_C_PDN]; // R5
            r_next.iso = wr_data[PBC_C_ISO]; // R6
            r_next.colt = wr_data[PBC_C_COLT]; // R9
            if (!r_reg.an_en) begin
                r_next.spd = wr_data[PBC_C_SPD]; // R3 R4
                r_next.dpx = wr_data[PBC_C_DPX]; // R8
            end
            if (wr_data[PBC_C_ANRS] && r_reg.an_en && wr_data[PBC_C_ANEN]) begin
                r_next.restart = 1'b1; // R7
            end
            if (wr_data[PBC_C_RST]) begin
                r_next.srst = 1'b1; // R1
                r_next.srst_cnt = 8'(PBC_SRST_CYC);
            end
        end

        // Loopback at 100 Mbps costs descrambler lock for the dead time
        if (!r_reg.loop) begin
            r_next.dead = 1'b0;
            r_next.dead_cnt = 32'h0000_0000;
        end else if (r_next.loop && !r_reg.loop && spd_now) begin
            r_next.dead = 1'b1;
        end
        if (wr_ctrl && wr_data[PBC_C_LOOP] && !r_reg.loop && spd_now) begin
            r_next.dead = 1'b1; // R2
            r_next.dead_cnt = 32'(LOOP_DEAD_CYCLES);
        end else if (r_reg.loop && r_reg.dead_cnt != 32'h0000_0000) begin
            r_next.dead_cnt = r_reg.dead_cnt - 32'h0000_0001;
            r_next.dead = (r_reg.dead_cnt != 32'h0000_0001);
        end

        // Isolated or powered-down PHY gives the MAC no collision
        r_next.col = ~r_reg.iso & ~r_reg.pdn & (COL_LINE | (r_reg.colt & TX_EN)); // R9 R6
        r_next.spd_o = spd_now;
        r_next.dpx_o = dpx_now;

        // Whole bank held at defaults while the software reset runs
        if (r_reg.srst) begin
            r_next = RST_S; // R1
            r_next.mdc_d = pin_s[1];
            r_next.srst = (r_reg.srst_cnt != 8'h01);
            r_next.srst_cnt = r_reg.srst_cnt - 8'h01;
            r_next.rd_data = r_reg.rd_data;
        end

        if (rd_req) begin
            case (addr)
                PBC_REG_CTRL: r_next.rd_data = ctrl_rd;
                PBC_REG_STAT: r_next.rd_data = stat_rd;
                default: r_next.rd_data = 16'h0000; // R16
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            r_reg <= RST_S;
        end else begin
            r_reg <= r_next;
        end
    end

    assign COL = r_reg.col;
    assign AN_RESTART = r_reg.restart;
    assign AN_ENABLE = r_reg.an_en;
    assign SOFT_RESET = r_reg.srst;
    assign LOOPBACK = r_reg.loop;
    assign SPEED_100 = r_reg.spd_o;
    assign FULL_DUPLEX = r_reg.dpx_o;
    assign POWER_DOWN = r_reg.pdn;
    assign ISOLATE = r_reg.iso;
    assign LOOP_DEAD = r_reg.dead;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    chk_srst_hold: assert property ( // R1
        wr_ctrl && wr_data[PBC_C_RST] |=> SOFT_RESET [*8] ##1 !LOOPBACK && AN_ENABLE)
        else $error("soft reset did not hold the bank at defaults");
    chk_col_test: assert property ( // R9
        r_reg.colt && TX_EN && !ISOLATE && !POWER_DOWN |=> COL)
        else $error("collision test did not follow transmit enable");
    chk_ctrl_rsvd: assert property ( // R10
        rd_req && addr == PBC_REG_CTRL |=> r_reg.rd_data[6:0] == 7'h00)
        else $error("reserved control bits read non-zero");
    chk_stat_fixed: assert property ( // R11
        rd_stat |=> r_reg.rd_data[15:6] == 10'h1e0 && r_reg.rd_data[3] && r_reg.rd_data[0])
        else $error("status ability bits wrong");
    chk_link_low: assert property ( // R14
        !LINK_OK && !r_reg.srst |=> !r_reg.link [*1] ##0 !(rd_stat))
        else $error("link status did not latch low");
    chk_link_rearm: assert property ( // R19
        rd_stat && LINK_OK && !r_reg.srst |=> r_reg.link)
        else $error("status read did not re-arm the link latch");
    chk_jab_10m: assert property ( // R15
        JABBER && !AN_ENABLE && !r_reg.spd && !r_reg.srst |=> r_reg.jab)
        else $error("jabber not latched at 10 Mbps");
    chk_fault_hold: assert property ( // R13
        r_reg.fault && !rd_stat && !r_reg.srst |=> r_reg.fault)
        else $error("remote fault dropped without a read");
    chk_restart_off: assert property ( // R7
        !AN_ENABLE |=> !AN_RESTART)
        else $error("restart pending with negotiation disabled");
    chk_speed_read: assert property ( // R3
        rd_req && addr == PBC_REG_CTRL && AN_ENABLE && !r_reg.srst
        |=> r_reg.rd_data[PBC_C_SPD] == $past(AN_SPEED_100))
        else $error("control read did not show negotiated speed");
    chk_unmapped: assert property ( // R16
        rd_req && addr > PBC_REG_STAT |=> r_reg.rd_data == 16'h0000)
        else $error("unimplemented address read non-zero");
    chk_iso_col: assert property ( // R6
        ISOLATE |=> !COL)
        else $error("collision reached the MAC while isolated");
    chk_dead_clear: assert property ( // R2
        !LOOPBACK && !wr_ctrl |=> !LOOP_DEAD)
        else $error("dead time kept running with loopback off");

    cov_stat_read: cover property (rd_stat);
    cov_ctrl_write: cover property (wr_ctrl);
    cov_soft_reset: cover property ($fell(SOFT_RESET));
    cov_loop_dead: cover property ($rose(LOOP_DEAD));
endmodule

/* pbc_phy_regs_tb_top.sv */
// Self-checking bench of the PHY basic control and status bank
`timescale 1ns/1ps
module pbc_phy_regs_tb_top;
    import pbc_pkg::*;
    logic        sys_clk, mdc, mdio, mdio_out, mdio_oe, col, an_restart;
    logic        an_enable, soft_reset, loopback, speed_100, full_duplex;
    logic        power_down, isolate, loop_dead;
    logic        sys_rst = 1'b1;
    logic        tx_en   = 1'b0;
    logic        an_s100 = 1'b1;
    logic        an_fdx  = 1'b1;
    logic [3:0]  evt     = 4'h0;
    logic [15:0] rd;
    int          errors  = 0;
    int          n_tests = 0;
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    pbc_phy_regs #(.LOOP_DEAD_CYCLES(50)) u_pbc_phy_regs (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
        .MDC(mdc), .MDIO_IN(mdio), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe), .TX_EN(tx_en),
        .COL_LINE(1'b0), .COL(col), .LINK_OK(~evt[3]), .JABBER(evt[0]),
        .PARTNER_FAULT(evt[1]), .AN_COMPLETE(1'b1), .AN_SPEED_100(an_s100),
        .AN_FULL_DUPLEX(an_fdx), .AN_STARTED(evt[2]), .AN_RESTART(an_restart),
        .AN_ENABLE(an_enable), .SOFT_RESET(soft_reset), .LOOPBACK(loopback),
        .SPEED_100(speed_100), .FULL_DUPLEX(full_duplex), .POWER_DOWN(power_down),
        .ISOLATE(isolate), .LOOP_DEAD(loop_dead));
    pbc_sta_model u_pbc_sta_model (.dev_out(mdio_out), .dev_oe(mdio_oe), .mdc(mdc),
        .mdio(mdio));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic close_out();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Mode outputs packed: enable, speed, duplex, down, isolate, loop, restart
    task automatic pv(input logic [15:0] exp);
        chk({9'h000, an_enable, speed_100, full_duplex, power_down, isolate, loopback,
             an_restart}, exp);
    endtask
    task automatic rc(input logic [4:0] a, input logic [15:0] exp);
        u_pbc_sta_model.frame(PBC_OP_RD, a, 16'h0000, rd);
        repeat (4) @(posedge sys_clk);
        chk(rd, exp);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        u_pbc_sta_model.frame(PBC_OP_WR, a, d, rd);
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic pulse(input int k);
        @(posedge sys_clk) evt[k] <= 1'b1;
        @(posedge sys_clk) evt[k] <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic run_latches();
        pulse(3);
        rc(PBC_REG_STAT, 16'h7829);
        rc(PBC_REG_STAT, 16'h782d);
        pulse(1);
        rc(PBC_REG_STAT, 16'h783d);
        pulse(0);
        rc(PBC_REG_STAT, 16'h782d);
        @(posedge sys_clk) an_s100 <= 1'b0;
        an_fdx <= 1'b0;
        rc(PBC_REG_CTRL, 16'h1000);
        pv(16'h0040);
        pulse(0);
        rc(PBC_REG_STAT, 16'h782f);
        rc(PBC_REG_STAT, 16'h782d);
        @(posedge sys_clk) an_s100 <= 1'b1;
        an_fdx <= 1'b1;
    endtask
    task automatic run_manual_restart();
        wr(PBC_REG_CTRL, 16'h0000);
        rc(PBC_REG_CTRL, 16'h2100);
        wr(PBC_REG_CTRL, 16'h0000);
        rc(PBC_REG_CTRL, 16'h0000);
        pv(16'h0000);
        pulse(0);
        rc(PBC_REG_STAT, 16'h782f);
        wr(PBC_REG_CTRL, 16'h0200);
        wr(PBC_REG_CTRL, 16'h1200);
        pv(16'h0070);
        wr(PBC_REG_CTRL, 16'h1200);
        rc(PBC_REG_CTRL, 16'h3300);
        wr(PBC_REG_CTRL, 16'h1000);
        pv(16'h0071);
        pulse(2);
        rc(PBC_REG_CTRL, 16'h3100);
    endtask
    task automatic run_modes();
        wr(PBC_REG_CTRL, 16'h1080);
        rc(PBC_REG_CTRL, 16'h3180);
        @(posedge sys_clk) tx_en <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(col, 1'b1);
        wr(PBC_REG_CTRL, 16'h1480);
        pv(16'h0074);
        chk(col, 1'b0);
        wr(PBC_REG_CTRL, 16'h1880);
        pv(16'h0078);
        @(posedge sys_clk) tx_en <= 1'b0;
        wr(PBC_REG_CTRL, 16'h5000);
        pv(16'h0072);
        chk(loop_dead, 1'b1);
        for (int i = 0; i < 60 && loop_dead; i++) @(posedge sys_clk);
        chk(loop_dead, 1'b0);
        rc(5'h10, 16'h0000);
        rc(5'h02, 16'h0000);
    endtask
    task automatic run_soft_reset();
        wr(PBC_REG_CTRL, 16'h8000);
        chk(soft_reset, 1'b1);
        for (int i = 0; i < 40 && soft_reset; i++) @(posedge sys_clk);
        chk(soft_reset, 1'b0);
        pv(16'h0070);
        rc(PBC_REG_CTRL, 16'h3100);
        rc(PBC_REG_STAT, 16'h7829);
    endtask
    initial begin
        #2ms;
        errors++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        pv(16'h0070);
        rc(PBC_REG_CTRL, 16'h3100);
        rc(PBC_REG_STAT, 16'h7829);
        rc(PBC_REG_STAT, 16'h782d);
        run_latches();
        run_manual_restart();
        run_modes();
        run_soft_reset();
        close_out();
    end
endmodule

/* pbc_pkg.sv */
// Package: constants and types of the PHY basic control and status bank
package pbc_pkg;
    // ****************************************************************
    // Clock and register map
    // ****************************************************************
    localparam int         PBC_CLK_MHZ   = 40;
    localparam logic [4:0] PBC_REG_CTRL  = 5'h00;
    localparam logic [4:0] PBC_REG_STAT  = 5'h01;
    localparam logic [4:0] PBC_PHY_ADDR  = 5'h01;
    localparam logic [4:0] PBC_REG_LAST  = 5'h12;
    localparam logic [4:0] PBC_RSV_FIRST = 5'h07;
    localparam logic [4:0] PBC_RSV_LAST  = 5'h0f;
    // ****************************************************************
    // Control bit positions and reset values
    // ****************************************************************
    localparam int PBC_C_RST  = 15;
    localparam int PBC_C_LOOP = 14;
    localparam int PBC_C_SPD  = 13;
    localparam int PBC_C_ANEN = 12;
    localparam int PBC_C_PDN  = 11;
    localparam int PBC_C_ISO  = 10;
    localparam int PBC_C_ANRS = 9;
    localparam int PBC_C_DPX  = 8;
    localparam int PBC_C_COLT = 7;
    localparam logic       PBC_SPD_RST  = 1'b1;
    localparam logic       PBC_ANEN_RST = 1'b1;
    localparam logic       PBC_DPX_RST  = 1'b1;
    localparam logic [6:0] PBC_CTRL_RSV = 7'h00;
    // ****************************************************************
    // Status fields
    // ****************************************************************
    localparam logic [4:0] PBC_STAT_ABIL = 5'h0f;
    localparam logic [3:0] PBC_STAT_RSV  = 4'h0;
    localparam logic       PBC_STAT_NOPRE = 1'b0;
    localparam logic       PBC_STAT_ANAB = 1'b1;
    localparam logic       PBC_STAT_EXT  = 1'b1;
    // ****************************************************************
    // Management frame
    // ****************************************************************
    localparam int         PBC_PRE_BITS  = 32;
    localparam int         PBC_HDR_BITS  = 14;
    localparam int         PBC_DATA_BITS = 16;
    localparam logic [1:0] PBC_ST        = 2'b01;
    localparam logic [1:0] PBC_OP_RD     = 2'b10;
    localparam logic [1:0] PBC_OP_WR     = 2'b01;
    typedef enum logic [1:0] {
        PBC_MS_PRE  = 2'b00,
        PBC_MS_HDR  = 2'b01,
        PBC_MS_TA   = 2'b10,
        PBC_MS_DATA = 2'b11
    } pbc_mdio_st_t;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int PBC_SRST_NS       = 500;
    localparam int PBC_SRST_CYC      = (PBC_SRST_NS * PBC_CLK_MHZ + 999) / 1000;
    localparam int PBC_LOOP_DEAD_MS  = 720;
    localparam int PBC_LOOP_DEAD_CYC = PBC_LOOP_DEAD_MS * PBC_CLK_MHZ * 1000;
endpackage

/* pbc_sta_model.sv */
// Station management model that bit-bangs frames on the management link
`timescale 1ns/1ps
module pbc_sta_model
    import pbc_pkg::*;
(
    input  logic dev_out,   // Data driven by the device
    input  logic dev_oe,    // Device drives the data wire
    output logic mdc,       // Management clock, still between frames
    output logic mdio       // Resolved data wire level
);
    logic host_oe  = 1'b0;
    logic host_bit = 1'b1;
    // Pull-up holds the wire high whenever nobody drives it
    assign mdio = dev_oe ? dev_out : (host_oe ? host_bit : 1'b1);
    initial mdc = 1'b0;
    // ****************************************************************
    // Frame driver
    // ****************************************************************
    // Data changes while the clock is low; read data is taken late in the high
    // phase because the device answers a few system cycles after the fall
    task automatic bit_io(input logic b, input logic drv, output logic s);
        host_oe = drv;
        host_bit = b;
        #100 mdc = 1'b1;
        #95 s = mdio;
        #5 mdc = 1'b0;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        logic        s;
        // Full preamble always precedes the header; only defined addresses
        f = {32'hffffffff, PBC_ST, op, PBC_PHY_ADDR, ra, 2'b10, wd};
        #7;
        for (int i = 63; i >= 0; i--) begin
            bit_io(f[i], (i >= 18) || (op == PBC_OP_WR), s);
            if (i < 16) begin
                rd[i] = s;
            end
        end
        host_oe = 1'b0;
    endtask
endmodule

/* pbc_sync2.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pbc_sync2 #(
    parameter int WIDTH = 2
) (
    input  logic             clk,   // System clock
    input  logic             rst,   // Synchronous reset, active high
    input  logic [WIDTH-1:0] d,     // Asynchronous inputs
    output logic [WIDTH-1:0] q      // Synchronised outputs
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } pbc_sync_t;

    pbc_sync_t r_reg;
    pbc_sync_t r_next;

    // First stage feeds only the second stage
    always_comb begin
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.s2;
endmodule
